// ===== core/hws_consts.svh
// Purpose: timing counts and reset values for the host wake-out block
// Assumes: core clock of 40 MHz
// Notes: every count derived from a time in its own unit
`ifndef HWS_CONSTS_SVH
`define HWS_CONSTS_SVH
`define HWS_CLK_HZ 40000000
`define HWS_TICK_MS 1
`define HWS_MS_CYCLES ((`HWS_CLK_HZ / 1000) * `HWS_TICK_MS)
`define HWS_MS_PER_S 1000
`define HWS_MS_CNT_W 16
`define HWS_S_CNT_W 10
`define HWS_SET_W 8
`define HWS_DELAY_OFF 8'h00
`define HWS_WAKE_RST 1'b1
`endif

// ===== core/hws_pkg.sv
// Purpose: types for the host wake-out block
// Assumes: nothing
// Notes: state codes written out
package hws_pkg;
	typedef enum logic [1:0]
	{
		HWS_IDLE = 2'b00,
		HWS_DELAY = 2'b01,
		HWS_SEND = 2'b10,
		HWS_HOLD = 2'b11
	} hws_state_e;
endpackage

// ===== core/hws_wake.sv
// Purpose: wake-out handshake toward a sleeping host
// Assumes: send request and serial activity come from core-clock logic
// Notes: settings are plain inputs, there is no register bus
`timescale 1ns/10ps
`include "hws_consts.svh"
module hws_wake
(
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	// settings
	input wire logic [`HWS_SET_W-1:0] WAKE_DELAY_MS_SETTING_IN,
	input wire logic [`HWS_SET_W-1:0] MIN_WAKE_DURATION_SETTING_IN,
	// serial side
	input wire logic TX_PENDING_IN,
	input wire logic BYTE_DONE_IN,
	input wire logic RX_BYTE_IN,
	input wire logic FLOW_OK_IN,
	// outputs
	output logic WAKE_OUT_N_OUT,
	output logic TX_ALLOW_OUT,
	output logic WINDOW_OPEN_OUT
);
	//--------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------
	hws_pkg::hws_state_e state; // current state
	hws_pkg::hws_state_e next_state; // next state
	logic [`HWS_MS_CNT_W-1:0] ms_pre; // cycles within a ms
	logic [`HWS_S_CNT_W-1:0] s_pre; // ms within a second
	logic [`HWS_SET_W:0] delay_cnt; // ms ticks left, one spare tick
	logic [`HWS_SET_W-1:0] win_cnt; // seconds left of window
	logic ms_tick; // one ms pulse
	logic s_tick; // one s pulse
	wire enabled; // mechanism on
	wire activity; // any serial byte
	wire window; // window still running
	wire delay_done; // delay elapsed
	assign enabled = WAKE_DELAY_MS_SETTING_IN != `HWS_DELAY_OFF;
	assign activity = BYTE_DONE_IN | RX_BYTE_IN;
	assign window = win_cnt != '0;
	assign delay_done = delay_cnt == '0;

	//--------------------------------------------------------------
	// tick generation
	//--------------------------------------------------------------
	wire ms_wrap;
	wire s_wrap;
	assign ms_wrap = ms_pre == `HWS_MS_CNT_W'(`HWS_MS_CYCLES - 1);
	assign s_wrap = s_pre == `HWS_S_CNT_W'(`HWS_MS_PER_S - 1);
	// prescalers for ms and s ticks
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			ms_pre <= '0;
			s_pre <= '0;
			ms_tick <= 1'b0;
			s_tick <= 1'b0;
		end
		else
		begin
			ms_pre <= ms_wrap ? '0 : ms_pre + 1'b1;
			ms_tick <= ms_wrap;
			if (ms_wrap)
				s_pre <= s_wrap ? '0 : s_pre + 1'b1;
			s_tick <= ms_wrap & s_wrap;
		end
	end

	//--------------------------------------------------------------
	// wake window timer
	//--------------------------------------------------------------
	// reload on every byte while enabled, clear while disabled, count seconds down otherwise
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			win_cnt <= '0;
		else if (activity & enabled)
			win_cnt <= MIN_WAKE_DURATION_SETTING_IN;
		else if (!enabled)
			win_cnt <= '0;
		else if (s_tick && window)
			win_cnt <= win_cnt - 1'b1;
	end

	//--------------------------------------------------------------
	// delay timer
	//--------------------------------------------------------------
	// loaded on wake assertion, counts ms down
	// one tick above the setting: the free-running ms tick may come
	// right after the load, and the wait must never fall short
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
			delay_cnt <= '0;
		else if (state == hws_pkg::HWS_IDLE)
			delay_cnt <= {1'b0, WAKE_DELAY_MS_SETTING_IN} + 1'b1;
		else if (ms_tick && !delay_done)
			delay_cnt <= delay_cnt - 1'b1;
	end

	//--------------------------------------------------------------
	// sequence
	//--------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			hws_pkg::HWS_IDLE:
				// pending data: wake first, or send directly in window
				if (TX_PENDING_IN && enabled)
					next_state = window ? hws_pkg::HWS_HOLD :
						hws_pkg::HWS_DELAY;
			hws_pkg::HWS_DELAY:
				if (!enabled)
					next_state = hws_pkg::HWS_IDLE;
				else if (delay_done)
					next_state = hws_pkg::HWS_SEND;
			hws_pkg::HWS_SEND:
				// done sending releases the line
				if (!TX_PENDING_IN || !enabled)
					next_state = hws_pkg::HWS_IDLE;
			hws_pkg::HWS_HOLD:
				// in-window send, line stays high
				if (!TX_PENDING_IN || !enabled)
					next_state = hws_pkg::HWS_IDLE;
		endcase
	end

	// state and registered outputs
	wire next_low;
	wire next_allow;
	assign next_low = next_state == hws_pkg::HWS_DELAY ||
		next_state == hws_pkg::HWS_SEND;
	assign next_allow = (next_state == hws_pkg::HWS_SEND ||
		next_state == hws_pkg::HWS_HOLD) && FLOW_OK_IN;
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RST_IN)
		begin
			state <= hws_pkg::HWS_IDLE;
			WAKE_OUT_N_OUT <= `HWS_WAKE_RST;
			TX_ALLOW_OUT <= 1'b0;
			WINDOW_OPEN_OUT <= 1'b0;
		end
		else
		begin
			state <= next_state;
			WAKE_OUT_N_OUT <= ~next_low;
			TX_ALLOW_OUT <= next_allow;
			WINDOW_OPEN_OUT <= window;
		end
	end

	//--------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------
	// line high one cycle after the mechanism is off
	a_disabled_line_high: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		!enabled |=> WAKE_OUT_N_OUT)
		else $error("wake line low while disabled");
	// no permission to send while the delay runs
	a_no_send_in_delay: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		state == hws_pkg::HWS_DELAY |-> !TX_ALLOW_OUT)
		else $error("send allowed during delay");
	// permission drops one cycle after flow control does
	a_flow_gates_send: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		!FLOW_OK_IN |=> !TX_ALLOW_OUT)
		else $error("send without flow control");
	// line stays low for the whole woken send
	a_low_while_send: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		state == hws_pkg::HWS_SEND |-> !WAKE_OUT_N_OUT)
		else $error("line high while sending");
	// end of pending data frees the line next cycle
	a_release_after_send: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		state == hws_pkg::HWS_SEND && !TX_PENDING_IN |=> WAKE_OUT_N_OUT)
		else $error("line not released");
	// in-window send: line untouched, no delay
	a_window_no_wake: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		state == hws_pkg::HWS_IDLE && window && TX_PENDING_IN && enabled
		|=> WAKE_OUT_N_OUT && TX_ALLOW_OUT == $past(FLOW_OK_IN))
		else $error("wake reasserted in window");
	// every byte while enabled reloads the window to the setting
	a_window_reload: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		activity && enabled
		|=> win_cnt == $past(MIN_WAKE_DURATION_SETTING_IN))
		else $error("window not restarted");
	// idle means the line rests high
	a_idle_line_high: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		state == hws_pkg::HWS_IDLE |-> WAKE_OUT_N_OUT)
		else $error("line low when idle");
	// ms tick is a lone pulse
	a_ms_tick_period: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		ms_tick |=> !ms_tick [*8])
		else $error("ms tick too frequent");

	//--------------------------------------------------------------
	// coverage of the main scenarios
	//--------------------------------------------------------------
	c_wake_send: cover property (@(posedge CORE_CLK_IN)
		state == hws_pkg::HWS_DELAY ##1 state == hws_pkg::HWS_SEND);
	c_window_send: cover property (@(posedge CORE_CLK_IN)
		state == hws_pkg::HWS_HOLD);
	c_flow_stall: cover property (@(posedge CORE_CLK_IN)
		state == hws_pkg::HWS_SEND && !FLOW_OK_IN);
	c_delay_abort: cover property (@(posedge CORE_CLK_IN)
		state == hws_pkg::HWS_DELAY && !enabled);
	c_window_restart: cover property (@(posedge CORE_CLK_IN)
		activity && window);
endmodule // hws_wake

// ===== verif/host_wakeup_signaling_bench.sv
// Purpose: self-checking bench for the wake-out block
// Assumes: 40 MHz clock, 1 ms delay setting
// Notes: window expiry in seconds is too long to run
`timescale 1ns/10ps
module host_wakeup_signaling_bench;
	logic clk = 0, rst = 1, pend = 0, bdone = 0, stall = 0, rxr = 0;
	logic [7:0] dly = 8'h00, win = 8'h05;
	logic wk, alw, wo, fok, rxb;
	int failures = 0, n_tests = 0;
	bit hung = 0; // wait for send permission ran out
	always #12.5 clk = ~clk;
	hws_wake DUT (.CORE_CLK_IN(clk), .RST_IN(rst),
		.WAKE_DELAY_MS_SETTING_IN(dly),
		.MIN_WAKE_DURATION_SETTING_IN(win), .TX_PENDING_IN(pend),
		.BYTE_DONE_IN(bdone), .RX_BYTE_IN(rxb), .FLOW_OK_IN(fok),
		.WAKE_OUT_N_OUT(wk), .TX_ALLOW_OUT(alw), .WINDOW_OPEN_OUT(wo));
	hws_host_model host (.clk_in(clk), .rst_in(rst), .wake_n_in(wk),
		.window_in(wo), .stall_in(stall), .rx_req_in(rxr),
		.flow_ok_out(fok), .rx_byte_out(rxb));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// outputs at reset release
	task automatic t_reset();
		chk("wake", 1, wk);
		chk("allow", 0, alw);
		chk("window", 0, wo);
	endtask
	// zero delay setting ignores pending data
	task automatic t_off();
		pend = 1;
		cyc(5);
		chk("wake", 1, wk);
		chk("allow", 0, alw);
		pend = 0;
		cyc(1);
	endtask
	// full wake: line low, delay, flow stall, release
	task automatic t_wake();
		int i;
		dly = 8'h01;
		pend = 1;
		cyc(2);
		chk("wake", 0, wk);
		chk("allow", 0, alw);
		// 1 ms setting waits one to two ms of ticks
		for (i = 0; i < 80100 && alw !== 1'b1; i++)
			cyc(1);
		if (alw !== 1'b1)
			hung = 1;
		chk("allow", 1, alw);
		chk("wake", 0, wk);
		stall = 1;
		cyc(2);
		chk("allow", 0, alw);
		stall = 0;
		bdone = 1;
		cyc(1);
		bdone = 0;
		cyc(1);
		chk("allow", 1, alw);
		pend = 0;
		cyc(2);
		chk("wake", 1, wk);
		chk("allow", 0, alw);
		chk("window", 1, wo);
	endtask
	// send inside the window after a host byte
	task automatic t_again();
		rxr = 1;
		cyc(1);
		rxr = 0;
		pend = 1;
		cyc(2);
		chk("allow", 1, alw);
		chk("wake", 1, wk);
		pend = 0;
		cyc(2);
		chk("window", 1, wo);
	endtask
	// clearing the setting mid-delay aborts
	task automatic t_abort();
		dly = 8'h00;
		cyc(2);
		chk("window", 0, wo);
		dly = 8'h01;
		pend = 1;
		cyc(2);
		chk("wake", 0, wk);
		dly = 8'h00;
		cyc(2);
		chk("wake", 1, wk);
		pend = 0;
	endtask
	initial
	begin
		cyc(16);
		rst = 0;
		t_reset();
		t_off();
		t_wake();
		// a timed-out wait goes straight to the report
		if (!hung)
		begin
			t_again();
			t_abort();
		end
		give_verdict();
	end
endmodule // host_wakeup_signaling_bench

// ===== verif/hws_host_model.sv
// Purpose: host controller model facing the wake line
// Assumes: core clock, synchronous active-high reset
// Notes: flow permit only while awake and not stalled
`timescale 1ns/10ps
module hws_host_model
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// wake side
	input wire logic wake_n_in,
	input wire logic window_in,
	// bench controls
	input wire logic stall_in,
	input wire logic rx_req_in,
	// serial side
	output logic flow_ok_out,
	output logic rx_byte_out
);
	logic awake; // serial port powered up
	// wake on low line, stay up through the window
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			awake <= 1'b0;
		else
			awake <= !wake_n_in || window_in;
	end
	assign flow_ok_out = awake && !stall_in;
	assign rx_byte_out = awake && rx_req_in;
endmodule // hws_host_model
